// file: udc_pkg.sv
// Package with constants and types of the up/down event counter bank
package udc_pkg;

  localparam int unsigned UDC_NUM_CNT  = 256;
  localparam int unsigned UDC_IDX_W    = 8;
  localparam int unsigned UDC_CNT_W    = 32;
  localparam int unsigned UDC_ADDR_W   = 12;
  localparam int unsigned UDC_DATA_W   = 32;

  // Register byte offsets
  localparam logic [11:0] UDC_OFS_SEL    = 12'h000;
  localparam logic [11:0] UDC_OFS_PRESET = 12'h004;
  localparam logic [11:0] UDC_OFS_DRIVE  = 12'h008;
  localparam logic [11:0] UDC_OFS_COUNT  = 12'h00C;
  localparam logic [11:0] UDC_OFS_STATUS = 12'h010;

  // Bit positions in the input-drive register and the status register
  localparam int unsigned UDC_BIT_UP     = 0;
  localparam int unsigned UDC_BIT_DOWN   = 1;
  localparam int unsigned UDC_BIT_ENABLE = 2;
  localparam int unsigned UDC_BIT_PRESET = 3;
  localparam int unsigned UDC_BIT_ZERO   = 0;

  localparam logic [31:0] UDC_CNT_RST    = 32'h0000_0000;
  localparam logic [31:0] UDC_PRESET_RST = 32'h0000_0000;
  localparam logic [7:0]  UDC_SEL_RST    = 8'h00;
  localparam logic [7:0]  UDC_IDX_LAST   = 8'hFF;
  localparam logic [31:0] UDC_ONE        = 32'h0000_0001;

  typedef enum logic [1:0] {
    UDC_INIT,
    UDC_IDLE,
    UDC_RD,
    UDC_RESP
  } udc_state_t;

  // Last seen levels of the four inputs of one counter
  typedef struct packed {
    logic count_preset_input;
    logic count_enable_input;
    logic count_down_input;
    logic count_up_input;
  } udc_lvl_t;

  localparam udc_lvl_t UDC_LVL_RST = '{
    count_preset_input: 1'b0,
    count_enable_input: 1'b1,
    count_down_input:   1'b0,
    count_up_input:     1'b0
  };

  typedef struct packed {
    logic [31:0] count;
    udc_lvl_t    lvl;
  } udc_entry_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } udc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } udc_apb_rsp_t;

  localparam udc_apb_rsp_t UDC_RSP_RST = '{
    pready:  1'b0,
    pslverr: 1'b0,
    prdata:  32'h0000_0000
  };

endpackage

// file: udc_mem.sv
// Counter storage: one entry per counter, registered read data
`timescale 1ns/1ns
module udc_mem
  import udc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rd_addr,
  output udc_entry_t      rd_data_r,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  udc_entry_t      wr_data
);

  udc_entry_t mem [UDC_NUM_CNT];

  // No reset on the array; the bank sweeps every entry after reset
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= mem[rd_addr];
  end

endmodule

// file: udc_bank.sv
// Bank of 256 signed up/down event counters behind an APB slave
// Function
// - 256 counters, each with status and up, down, enable, preset inputs.
// - Each count is held as a 32-bit signed two's complement value.
// - Rising edge on up input adds one while the counter is enabled.
// - Rising edge on down input subtracts one while the counter is enabled.
// - Enable low makes up and down edges ignored until enable returns high.
// - Activation sets every counter's enable input to one by default.
// - Rising edge on preset input loads the supplied preset value.
// - Status reads one when the count is zero, otherwise zero.
// - Full count is readable at any time apart from the status bit.
// - No snapshot kept; every read returns the live count and status.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module udc_bank
  import udc_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst,
  input  udc_apb_req_t apb_req,
  output udc_apb_rsp_t apb_rsp
);

  typedef struct packed {
    udc_state_t   st;
    logic [7:0]   init_idx;
    logic [7:0]   sel;
    logic [31:0]  preset_val;
    udc_apb_rsp_t rsp;
  } udc_regs_t;

  udc_regs_t  s_r;
  udc_regs_t  s_nxt;

  udc_entry_t mem_rd_data;
  logic [7:0] mem_rd_addr;
  logic       mem_wr_en;
  logic [7:0] mem_wr_addr;
  udc_entry_t mem_wr_data;

  udc_lvl_t   new_lvl;
  logic       up_edge;
  logic       down_edge;
  logic       preset_edge;
  // Plain 32-bit vector: signed wrap comes free from unsigned add and subtract
  logic [31:0] new_count;

  function automatic logic udc_hit(input logic [11:0] addr,
                                   input logic [11:0] ofs);
    udc_hit = (addr[11:2] == ofs[11:2]);
  endfunction

  function automatic logic udc_mapped(input logic [11:0] addr);
    udc_mapped = udc_hit(addr, UDC_OFS_SEL) ||
                 udc_hit(addr, UDC_OFS_PRESET) ||
                 udc_hit(addr, UDC_OFS_DRIVE) ||
                 udc_hit(addr, UDC_OFS_COUNT) ||
                 udc_hit(addr, UDC_OFS_STATUS);
  endfunction

  // One storage entry per counter keeps 256 counts off flip-flops
  udc_mem u_mem (
    .clk       (clk),
    .rd_addr   (mem_rd_addr),
    .rd_data_r (mem_rd_data),
    .wr_en     (mem_wr_en),
    .wr_addr   (mem_wr_addr),
    .wr_data   (mem_wr_data)
  );

  // Edges are found against the levels stored at the previous drive write
  always_comb begin
    new_lvl.count_up_input     = apb_req.pwdata[UDC_BIT_UP];
    new_lvl.count_down_input   = apb_req.pwdata[UDC_BIT_DOWN];
    new_lvl.count_enable_input = apb_req.pwdata[UDC_BIT_ENABLE];
    new_lvl.count_preset_input = apb_req.pwdata[UDC_BIT_PRESET];
    up_edge     = new_lvl.count_up_input &
                  ~mem_rd_data.lvl.count_up_input;
    down_edge   = new_lvl.count_down_input &
                  ~mem_rd_data.lvl.count_down_input;
    preset_edge = new_lvl.count_preset_input &
                  ~mem_rd_data.lvl.count_preset_input;
    new_count = mem_rd_data.count;
    if (preset_edge) begin
      new_count = s_r.preset_val;
    end else if (new_lvl.count_enable_input) begin
      if (up_edge && !down_edge) begin
        new_count = mem_rd_data.count + UDC_ONE;
      end else if (down_edge && !up_edge) begin
        new_count = mem_rd_data.count - UDC_ONE;
      end
    end
  end

  always_comb begin
    s_nxt       = s_r;
    mem_rd_addr = s_r.sel;
    mem_wr_en   = 1'b0;
    mem_wr_addr = s_r.sel;
    mem_wr_data = mem_rd_data;
    case (s_r.st)
      UDC_INIT: begin
        // Activation: zero count, enable high, other levels low
        mem_wr_en         = 1'b1;
        mem_wr_addr       = s_r.init_idx;
        mem_wr_data.count = UDC_CNT_RST;
        mem_wr_data.lvl   = UDC_LVL_RST;
        s_nxt.init_idx    = s_r.init_idx + 8'h01;
        if (s_r.init_idx == UDC_IDX_LAST) begin
          s_nxt.st = UDC_IDLE;
        end
      end
      UDC_IDLE: begin
        s_nxt.rsp = UDC_RSP_RST;
        if (apb_req.psel && apb_req.penable) begin
          s_nxt.st = UDC_RD;
        end
      end
      UDC_RD: begin
        s_nxt.st          = UDC_RESP;
        s_nxt.rsp.pready  = 1'b1;
        s_nxt.rsp.pslverr = !udc_mapped(apb_req.paddr);
        s_nxt.rsp.prdata  = 32'h0000_0000;
        if (!apb_req.pwrite) begin
          // Level, count and status reads come from storage directly, never a held copy; sel and preset from registers
          if (udc_hit(apb_req.paddr, UDC_OFS_SEL)) begin
            s_nxt.rsp.prdata[7:0] = s_r.sel;
          end else if (udc_hit(apb_req.paddr, UDC_OFS_PRESET)) begin
            s_nxt.rsp.prdata = s_r.preset_val;
          end else if (udc_hit(apb_req.paddr, UDC_OFS_DRIVE)) begin
            s_nxt.rsp.prdata[3:0] = mem_rd_data.lvl;
          end else if (udc_hit(apb_req.paddr, UDC_OFS_COUNT)) begin
            s_nxt.rsp.prdata = mem_rd_data.count;
          end else if (udc_hit(apb_req.paddr, UDC_OFS_STATUS)) begin
            s_nxt.rsp.prdata[UDC_BIT_ZERO] =
              (mem_rd_data.count == UDC_CNT_RST);
          end
        end else begin
          if (udc_hit(apb_req.paddr, UDC_OFS_SEL)) begin
            s_nxt.sel = apb_req.pwdata[7:0];
          end else if (udc_hit(apb_req.paddr, UDC_OFS_PRESET)) begin
            // Preset is taken when written, whatever its source was
            s_nxt.preset_val = apb_req.pwdata;
          end else if (udc_hit(apb_req.paddr, UDC_OFS_DRIVE)) begin
            mem_wr_en         = 1'b1;
            mem_wr_data.count = new_count;
            mem_wr_data.lvl   = new_lvl;
          end
        end
      end
      UDC_RESP: begin
        s_nxt.st  = UDC_IDLE;
        s_nxt.rsp = UDC_RSP_RST;
      end
      default: begin
        s_nxt.st  = UDC_IDLE;
        s_nxt.rsp = UDC_RSP_RST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r.st         <= UDC_INIT;
      s_r.init_idx   <= UDC_SEL_RST;
      s_r.sel        <= UDC_SEL_RST;
      s_r.preset_val <= UDC_PRESET_RST;
      s_r.rsp        <= UDC_RSP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign apb_rsp = s_r.rsp;

endmodule

// file: udc_monitor.sv
// Checker of the APB answers of the counter bank
`timescale 1ns/1ns
module udc_monitor
  import udc_pkg::*;
(
  input wire logic    clk,
  input wire logic    rst,
  input udc_apb_req_t apb_req,
  input udc_apb_rsp_t apb_rsp
);
  wire logic       rdy = apb_rsp.pready;
  wire logic [9:0] wd  = apb_req.paddr[11:2];
  wire logic       err = apb_rsp.pslverr;
  wire logic       acc = apb_req.psel && apb_req.penable;
  wire logic       hit = wd <= 10'h004;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start;
    apb_req.psel && $rose(apb_req.penable);
  endsequence
  sequence s_rd;
    rdy && !apb_req.pwrite;
  endsequence
  // The long bound covers the initialising sweep after reset
  property p_answer;
    s_start |-> !rdy [*2] ##[1:298] rdy;
  endproperty
  property p_wr_zero;
    rdy && apb_req.pwrite |-> apb_rsp.prdata == '0;
  endproperty
  property p_zero_bit;
    s_rd ##0 wd == 10'h004 |-> apb_rsp.prdata[31:1] == '0;
  endproperty
  property p_levels;
    s_rd ##0 wd == 10'h002 |-> apb_rsp.prdata[31:4] == '0;
  endproperty
  AST_ANSWER: assert property (p_answer)
    else $error("access answered at the wrong time");
  AST_ONE_CYCLE: assert property (rdy |=> !rdy)
    else $error("ready held too long");
  AST_IN_ACCESS: assert property (rdy |-> acc)
    else $error("ready outside an access");
  AST_ERR_MAP: assert property (err |-> rdy && !hit)
    else $error("error on a mapped address");
  AST_OK_MAP: assert property (rdy && hit |-> !err)
    else $error("mapped address refused");
  AST_WR_ZERO: assert property (p_wr_zero)
    else $error("write returned data");
  AST_ZERO_BIT: assert property (p_zero_bit)
    else $error("status has more than one bit");
  AST_LEVELS: assert property (p_levels)
    else $error("level read too wide");
  AST_SWEEP: assert property ($fell(rst) |-> !rdy [*8])
    else $error("answer during the reset sweep");
endmodule

// file: udc_scan_model.sv
// Program-scan model: APB master driving the counter inputs
`timescale 1ns/1ns
module udc_scan_model
  import udc_pkg::*;
(
  input wire logic     clk,
  output udc_apb_req_t apb_req,
  input udc_apb_rsp_t  apb_rsp
);
  int n_hang = 0;
  initial apb_req = '0;
  // Preset comes as a constant or a register copy taken at call time
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 400);
    if (n >= 400) n_hang++;
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    // Released data no longer shows the old value
    apb_req <= '{1'b0, 1'b0, w, a, ~d};
  endtask
endmodule

// file: test_up_down_event_counter_bank.sv
// Self-checking bench of the up/down event counter bank
`timescale 1ns/1ns
module test_up_down_event_counter_bank
  import udc_pkg::*;
  ;
  logic         clk        = 1'b0;
  logic         rst        = 1'b1;
  udc_apb_req_t apb_req;
  udc_apb_rsp_t apb_rsp;
  int           n_fail     = 0;
  int           n_compared = 0;
  logic [31:0]  q;
  logic         e;
  initial begin
    forever #2 clk = ~clk;
  end
  udc_bank DUT (.clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp));
  udc_scan_model scan (.clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp));
  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, x);
    n_compared++;
    if (s !== x) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    scan.xfer(w, a, d, q, e);
    if (scan.n_hang != 0) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask
  task automatic drv(input logic [3:0] l);
    acc(1'b1, UDC_OFS_DRIVE, {28'h0, l});
  endtask
  task automatic cnt(input logic [31:0] x);
    rd("count", UDC_OFS_COUNT, x);
    rd("status", UDC_OFS_STATUS, {31'h0, x == 32'h0});
  endtask
  task automatic t_reset();
    rd("sel", UDC_OFS_SEL, 32'h0);
    rd("preset", UDC_OFS_PRESET, 32'h0);
    cnt(32'h0);
    rd("levels", UDC_OFS_DRIVE, 32'h4);
    acc(1'b1, UDC_OFS_SEL, {24'h0, UDC_IDX_LAST});
    rd("sel", UDC_OFS_SEL, {24'h0, UDC_IDX_LAST});
    rd("levels", UDC_OFS_DRIVE, 32'h4);
    $display("reset test done");
  endtask
  task automatic t_count();
    acc(1'b1, UDC_OFS_SEL, 32'h5);
    drv(4'h5);
    cnt(32'h1);
    drv(4'h4);
    drv(4'h6);
    cnt(32'h0);
    drv(4'h4);
    drv(4'h7);
    cnt(32'h0);
    drv(4'h0);
    drv(4'h1);
    cnt(32'h0);
    drv(4'h4);
    drv(4'h5);
    cnt(32'h1);
    acc(1'b1, UDC_OFS_SEL, 32'hFF);
    cnt(32'h0);
    $display("count test done");
  endtask
  task automatic t_preset();
    acc(1'b1, UDC_OFS_SEL, 32'h9);
    acc(1'b1, UDC_OFS_PRESET, 32'h7FFF_FFFF);
    rd("preset", UDC_OFS_PRESET, 32'h7FFF_FFFF);
    drv(4'hC);
    cnt(32'h7FFF_FFFF);
    drv(4'h5);
    cnt(32'h8000_0000);
    drv(4'h6);
    cnt(32'h7FFF_FFFF);
    acc(1'b1, UDC_OFS_PRESET, 32'h8000_0000);
    drv(4'hD);
    cnt(32'h8000_0000);
    drv(4'h6);
    cnt(32'h7FFF_FFFF);
    $display("preset test done");
  endtask
  task automatic t_map();
    acc(1'b1, UDC_OFS_COUNT, 32'h1234_5678);
    chk("slverr", {31'h0, e}, 32'h0);
    cnt(32'h7FFF_FFFF);
    acc(1'b0, 12'h014, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    chk("unmapped", q, 32'h0);
    $display("map test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_count();
    t_preset();
    t_map();
    final_report();
  end
endmodule
bind udc_bank udc_monitor mon (.clk(clk), .rst(rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp));
